// ==== scaa_alarm_top.sv ====
// channel alarm collection, enables, summaries and register port
//
// Function
// - channel summary reaches device alarm only when upstream enable bit 0 set
// - AIS-P summary reaches device alarm only when upstream enable bit 1 set
// - elastic-store overflow reaches device alarm only with upstream enable bit 2
// - aligner threshold flag sets on min or max violation, write 1 clears
// - internal parity error sets sticky flag bit 1, w1c, enabled by bit 1
// - out-of-frame sets sticky flag bit 2, w1c, enabled by bit 2
// - B1 parity failure sets sticky flag bit 3, w1c, enabled by bit 3
// - parallel transmit data parity error sets flag bit 4, w1c, enable bit 4
// - overhead serial input parity error sets flag bit 5, w1c, enable bit 5
// - group loss of sync sets sticky flag bit 6, cleared by writing 1
// - each of seven enable bits lets its flag into channel summary
// - four read-only bits report path AIS on STS 3, 6, 9, 12
// - channel summary reads 1 exactly when some enabled flag is set
// - AIS-P summary reads 1 when any AIS flag and its enable set
`timescale 1ns/1ps
`default_nettype none

module scaa_alarm_top
  import scaa_pkg::*;
(
  input  wire logic              sys_clk_i,
  input  wire logic              rst_n_i,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_i,
  input  wire logic [DATA_W-1:0] reg_wdata_i,
  input  wire logic              reg_wr_i,
  input  wire logic              reg_rd_i,
  output logic      [DATA_W-1:0] reg_rdata_o,
  // alarm sources
  input  wire logic              fifo_lvl_below_min_i,
  input  wire logic              fifo_lvl_above_max_i,
  input  wire logic              rx_int_parity_err_i,
  input  wire logic              rx_oof_i,
  input  wire logic              b1_parity_err_i,
  input  wire logic              fabric_parallel_tx_data_par_err_i,
  input  wire logic              fabric_overhead_serial_in_par_err_i,
  input  wire logic              fifo_oos_i,
  input  wire logic [AIS_W-1:0]  sts_ais_i,
  input  wire logic              es_overflow_i,
  // upward indications
  output logic                   dev_chan_alarm_o,
  output logic                   dev_ais_alarm_o,
  output logic                   dev_es_alarm_o,
  output logic                   irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [UP_W-1:0]  up_en_ff;
  logic [FL_W-1:0]  flag_en_ff;
  logic [AIS_W-1:0] ais_en_ff;
  logic [AIS_W-1:0] ais_ff;
  logic [FL_W-1:0]  irq_mask_ff;
  logic [FL_W-1:0]  flags;
  logic [FL_W-1:0]  flag_set;
  logic [FL_W-1:0]  flag_clr;
  logic             chan_sum;
  logic             ais_sum;
  logic             es_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [DATA_W-1:0] nxt_rdata;

  logic wr_up;
  logic wr_flags;
  logic wr_en;
  logic wr_ais_en;
  logic wr_mask;

  assign wr_up     = reg_wr_i && (reg_addr_i == UPSTREAM_EN_ADDR);
  assign wr_flags  = reg_wr_i && (reg_addr_i == ALARM_FLAGS_ADDR);
  assign wr_en     = reg_wr_i && (reg_addr_i == ALARM_EN_ADDR);
  assign wr_ais_en = reg_wr_i && (reg_addr_i == AIS_EN_A_ADDR);
  assign wr_mask   = reg_wr_i && (reg_addr_i == IRQ_MASK_ADDR);

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      up_en_ff <= RST_UP;
    end
    else if (wr_up)
    begin
      up_en_ff <= reg_wdata_i[UP_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flag_en_ff <= RST_FLAGS;
    end
    else if (wr_en)
    begin
      flag_en_ff <= reg_wdata_i[FL_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ais_en_ff <= RST_AIS;
    end
    else if (wr_ais_en)
    begin
      ais_en_ff <= reg_wdata_i[AIS_W-1:0];
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      irq_mask_ff <= RST_FLAGS;
    end
    else if (wr_mask)
    begin
      irq_mask_ff <= reg_wdata_i[FL_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky channel alarm flags

  always_comb
  begin
    flag_set = '0;
    flag_set[FL_THR_BIT] = fifo_lvl_below_min_i || fifo_lvl_above_max_i;
    flag_set[FL_PAR_BIT] = rx_int_parity_err_i;
    flag_set[FL_OOF_BIT] = rx_oof_i;
    flag_set[FL_B1_BIT]  = b1_parity_err_i;
    flag_set[FL_DIN_BIT] = fabric_parallel_tx_data_par_err_i;
    flag_set[FL_OH_BIT]  = fabric_overhead_serial_in_par_err_i;
    flag_set[FL_OOS_BIT] = fifo_oos_i;
  end

  assign flag_clr = wr_flags ? reg_wdata_i[FL_W-1:0] : '0;

  // set wins over a same-cycle clear
  for (genvar g = 0; g < FL_W; g++)
  begin : g_flag
    scaa_sticky_bit u_flag
    (
      .sys_clk_i (sys_clk_i),
      .rst_n_i   (rst_n_i),
      .set_i     (flag_set[g]),
      .clr_i     (flag_clr[g]),
      .flag_o    (flags[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // ais and elastic store status

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ais_ff <= RST_AIS;
    end
    else
    begin
      ais_ff <= sts_ais_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      es_ff <= 1'b0;
    end
    else
    begin
      es_ff <= es_overflow_i;
    end
  end

  assign chan_sum = |(flags & flag_en_ff);
  assign ais_sum  = |(ais_ff & ais_en_ff);

  assign dev_chan_alarm_o = chan_sum && up_en_ff[UP_CHAN_BIT];
  assign dev_ais_alarm_o  = ais_sum && up_en_ff[UP_AIS_BIT];
  assign dev_es_alarm_o   = es_ff && up_en_ff[UP_ES_BIT];

  assign irq_o = |(flags & irq_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // read port

  always_comb
  begin
    nxt_rdata = RST_BYTE;
    case (reg_addr_i)
      UPSTREAM_EN_ADDR: nxt_rdata[UP_W-1:0]  = up_en_ff;
      ALARM_FLAGS_ADDR: nxt_rdata[FL_W-1:0]  = flags;
      ALARM_EN_ADDR:    nxt_rdata[FL_W-1:0]  = flag_en_ff;
      AIS_FLAGS_A_ADDR: nxt_rdata[AIS_W-1:0] = ais_ff;
      AIS_EN_A_ADDR:    nxt_rdata[AIS_W-1:0] = ais_en_ff;
      IRQ_MASK_ADDR:    nxt_rdata[FL_W-1:0]  = irq_mask_ff;
      SUMMARY_ADDR:
      begin
        nxt_rdata[UP_CHAN_BIT] = chan_sum;
        nxt_rdata[UP_AIS_BIT]  = ais_sum;
        nxt_rdata[UP_ES_BIT]   = es_ff;
      end
      default:          nxt_rdata = RST_BYTE;
    endcase
  end

  // data only in the cycle after the read strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rdata_ff <= RST_BYTE;
    end
    else if (reg_rd_i)
    begin
      rdata_ff <= nxt_rdata;
    end
    else
    begin
      rdata_ff <= RST_BYTE;
    end
  end

  assign reg_rdata_o = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence clr_write_s(int b);
    wr_flags && reg_wdata_i[b];
  endsequence

  chan_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_up && !reg_wdata_i[UP_CHAN_BIT] |=> !dev_chan_alarm_o)
    else $error("channel summary passed while disabled");

  ais_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !up_en_ff[UP_AIS_BIT] |-> !dev_ais_alarm_o)
    else $error("ais-p passed while disabled");

  es_gate_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    es_overflow_i && up_en_ff[UP_ES_BIT] && !wr_up |=> dev_es_alarm_o)
    else $error("elastic store alarm not passed");

  thr_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (fifo_lvl_below_min_i || fifo_lvl_above_max_i) |=> flags[FL_THR_BIT])
    else $error("threshold flag not set");

  clr_one_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clr_write_s(FL_OOF_BIT) ##0 !rx_oof_i |=> !flags[FL_OOF_BIT])
    else $error("write one did not clear");

  hold_zero_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    flags[FL_B1_BIT] && !(wr_flags && reg_wdata_i[FL_B1_BIT]) |=> flags[FL_B1_BIT])
    else $error("flag lost without clear");

  set_wins_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    clr_write_s(FL_OOS_BIT) ##0 fifo_oos_i |=> flags[FL_OOS_BIT])
    else $error("clear beat persisting set");

  chan_sum_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == SUMMARY_ADDR |=> reg_rdata_o[UP_CHAN_BIT] == $past(chan_sum))
    else $error("summary read mismatch");

  ais_rd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == AIS_FLAGS_A_ADDR |=> reg_rdata_o[AIS_W-1:0] == $past(ais_ff))
    else $error("ais flags read mismatch");

  chan_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    flags[FL_B1_BIT] && flag_en_ff[FL_B1_BIT] && up_en_ff[UP_CHAN_BIT] |-> dev_chan_alarm_o)
    else $error("enabled channel alarm not passed");

  ais_pass_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    |(sts_ais_i & ais_en_ff) && up_en_ff[UP_AIS_BIT] && !wr_up && !wr_ais_en
      |=> dev_ais_alarm_o)
    else $error("enabled ais-p not passed");

  es_block_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    wr_up && !reg_wdata_i[UP_ES_BIT] |=> !dev_es_alarm_o)
    else $error("elastic store alarm passed while disabled");

  par_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_int_parity_err_i |=> flags[FL_PAR_BIT])
    else $error("internal parity flag not set");

  oof_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    rx_oof_i |=> flags[FL_OOF_BIT])
    else $error("out of frame flag not set");

  b1_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    b1_parity_err_i |=> flags[FL_B1_BIT])
    else $error("b1 flag not set");

  din_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fabric_parallel_tx_data_par_err_i |=> flags[FL_DIN_BIT])
    else $error("parallel data parity flag not set");

  oh_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fabric_overhead_serial_in_par_err_i |=> flags[FL_OH_BIT])
    else $error("overhead parity flag not set");

  oos_set_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fifo_oos_i |=> flags[FL_OOS_BIT])
    else $error("out of sync flag not set");

  ais_sum_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == SUMMARY_ADDR |=> reg_rdata_o[UP_AIS_BIT] == $past(ais_sum))
    else $error("ais summary read mismatch");

  unused_rd_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    reg_rd_i && reg_addr_i == ALARM_FLAGS_ADDR |=> !reg_rdata_o[FL_W])
    else $error("unused flag bit read as one");

endmodule // scaa_alarm_top

`default_nettype wire

// ==== scaa_pkg.sv ====
// shared register map, field positions and reset values for the channel alarm block
package scaa_pkg;

  localparam int unsigned ADDR_W = 20;
  localparam int unsigned DATA_W = 8;

  // register offsets (byte addresses on the plain register port)
  localparam logic [19:0] UPSTREAM_EN_ADDR  = 20'h30027;
  localparam logic [19:0] ALARM_FLAGS_ADDR  = 20'h30028;
  localparam logic [19:0] ALARM_EN_ADDR     = 20'h30029;
  localparam logic [19:0] AIS_FLAGS_A_ADDR  = 20'h3002a;
  localparam logic [19:0] SUMMARY_ADDR      = 20'h30026;
  localparam logic [19:0] AIS_EN_A_ADDR     = 20'h3002c;
  localparam logic [19:0] IRQ_MASK_ADDR     = 20'h300f0;

  // upstream enable fields
  localparam int unsigned UP_CHAN_BIT = 0;
  localparam int unsigned UP_AIS_BIT  = 1;
  localparam int unsigned UP_ES_BIT   = 2;
  localparam int unsigned UP_W        = 3;

  // channel alarm flag fields
  localparam int unsigned FL_THR_BIT  = 0;
  localparam int unsigned FL_PAR_BIT  = 1;
  localparam int unsigned FL_OOF_BIT  = 2;
  localparam int unsigned FL_B1_BIT   = 3;
  localparam int unsigned FL_DIN_BIT  = 4;
  localparam int unsigned FL_OH_BIT   = 5;
  localparam int unsigned FL_OOS_BIT  = 6;
  localparam int unsigned FL_W        = 7;

  localparam int unsigned AIS_W       = 4;

  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [2:0] RST_UP       = 3'h0;
  localparam logic [6:0] RST_FLAGS    = 7'h00;
  localparam logic [3:0] RST_AIS      = 4'h0;

endpackage : scaa_pkg

// ==== scaa_sticky_bit.sv ====
// one write-1-to-clear sticky flag where a set beats a clear
`timescale 1ns/1ps
`default_nettype none

module scaa_sticky_bit
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_ff;

  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      flag_ff <= 1'b0;
    end
    else if (set_i)
    begin
      flag_ff <= 1'b1;
    end
    else if (clr_i)
    begin
      flag_ff <= 1'b0;
    end
  end

  assign flag_o = flag_ff;

endmodule // scaa_sticky_bit

`default_nettype wire

// ==== tb.sv ====
// self-checking bench for the channel alarm block
`timescale 1ns/1ps
`default_nettype none

module tb;
  import scaa_pkg::*;

  logic              sys_clk_i;
  logic              rst_n_i;
  logic [ADDR_W-1:0] reg_addr_i;
  logic [DATA_W-1:0] reg_wdata_i;
  logic              reg_wr_i;
  logic              reg_rd_i;
  logic [DATA_W-1:0] reg_rdata_o;
  logic [6:0]        src;
  logic              thr_sel;
  logic [AIS_W-1:0]  ais_i;
  logic              es_i;
  logic              chan_o;
  logic              ais_o;
  logic              es_o;
  logic              irq_o;
  logic [7:0]        en_m;
  logic [7:0]        up_m;
  logic [7:0]        mask_m;
  logic [7:0]        aen_m;
  int                miscompares;
  int                comparisons;
  int                cyc;

  scaa_alarm_top dut
  (
    .sys_clk_i                           (sys_clk_i),
    .rst_n_i                             (rst_n_i),
    .reg_addr_i                          (reg_addr_i),
    .reg_wdata_i                         (reg_wdata_i),
    .reg_wr_i                            (reg_wr_i),
    .reg_rd_i                            (reg_rd_i),
    .reg_rdata_o                         (reg_rdata_o),
    .fifo_lvl_below_min_i                (src[0] & ~thr_sel),
    .fifo_lvl_above_max_i                (src[0] & thr_sel),
    .rx_int_parity_err_i                 (src[1]),
    .rx_oof_i                            (src[2]),
    .b1_parity_err_i                     (src[3]),
    .fabric_parallel_tx_data_par_err_i   (src[4]),
    .fabric_overhead_serial_in_par_err_i (src[5]),
    .fifo_oos_i                          (src[6]),
    .sts_ais_i                           (ais_i),
    .es_overflow_i                       (es_i),
    .dev_chan_alarm_o                    (chan_o),
    .dev_ais_alarm_o                     (ais_o),
    .dev_es_alarm_o                      (es_o),
    .irq_o                               (irq_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    if (miscompares == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // strobe is dropped on the next edge, so back-to-back calls leave one idle cycle
  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b1;
    reg_addr_i  <= a;
    reg_wdata_i <= d;
    @(posedge sys_clk_i);
    reg_wr_i    <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b1;
    reg_addr_i <= a;
    @(posedge sys_clk_i);
    reg_rd_i   <= 1'b0;
    @(negedge sys_clk_i);
    check("reg_rdata_o", exp, reg_rdata_o);
  endtask

  task automatic cfg();
    en_m   = 8'($urandom) & 8'h7f;
    up_m   = 8'($urandom) & 8'h07;
    mask_m = 8'($urandom) & 8'h7f;
    aen_m  = 8'($urandom) & 8'h0f;
    wr(ALARM_EN_ADDR, en_m);
    wr(UPSTREAM_EN_ADDR, up_m);
    wr(IRQ_MASK_ADDR, mask_m);
    wr(AIS_EN_A_ADDR, aen_m);
  endtask

  // summary byte from the sticky flags and the current enables
  function automatic logic [7:0] exp_sum(input logic [7:0] fl);
    exp_sum = {5'h0, es_i, |(ais_i & aen_m[3:0]), |(fl & en_m)};
  endfunction

  task automatic chk_out(input logic [7:0] fl);
    logic [7:0] s;
    @(negedge sys_clk_i);
    s = exp_sum(fl);
    check("dev_chan_alarm_o", {7'h0, up_m[0] & s[0]}, {7'h0, chan_o});
    check("irq_o", {7'h0, |(fl & mask_m)}, {7'h0, irq_o});
    check("dev_ais_alarm_o", {7'h0, up_m[1] & s[1]}, {7'h0, ais_o});
    check("dev_es_alarm_o", {7'h0, up_m[2] & s[2]}, {7'h0, es_o});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      close_out();
    end
  end

  initial
  begin
    logic [19:0] amap [8];
    logic [7:0]  bit_v;
    amap = '{SUMMARY_ADDR, UPSTREAM_EN_ADDR, ALARM_FLAGS_ADDR, ALARM_EN_ADDR,
             AIS_FLAGS_A_ADDR, AIS_EN_A_ADDR, IRQ_MASK_ADDR, 20'h30031};
    miscompares = 0;
    comparisons = 0;
    cyc = 0;
    rst_n_i = 1'b0;
    reg_addr_i = '0;
    reg_wdata_i = '0;
    reg_wr_i = 1'b0;
    reg_rd_i = 1'b0;
    src = '0;
    thr_sel = 1'b0;
    ais_i = '0;
    es_i = 1'b0;
    void'($urandom(85793));
    repeat (8) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    // reset values, unmapped place included
    foreach (amap[i]) rd(amap[i], 8'h00);
    foreach (amap[i]) wr(amap[i], 8'hff);
    rd(UPSTREAM_EN_ADDR, 8'h07);
    rd(ALARM_EN_ADDR, 8'h7f);
    rd(AIS_EN_A_ADDR, 8'h0f);
    rd(20'h30031, 8'h00);
    rd(ALARM_FLAGS_ADDR, 8'h00);
    // each source: set, write 0 keeps, persisting source beats write 1, then write 1 clears
    for (int b = 0; b < 7; b++)
    begin
      repeat (3)
      begin
        cfg();
        bit_v = 8'h01 << b;
        ais_i <= 4'($urandom);
        es_i <= 1'($urandom);
        thr_sel <= 1'($urandom);
        @(posedge sys_clk_i);
        src <= bit_v[6:0];
        @(posedge sys_clk_i);
        src <= '0;
        chk_out(bit_v);
        rd(ALARM_FLAGS_ADDR, bit_v);
        rd(SUMMARY_ADDR, exp_sum(bit_v));
        rd(AIS_FLAGS_A_ADDR, {4'h0, ais_i});
        wr(ALARM_FLAGS_ADDR, ~bit_v);
        rd(ALARM_FLAGS_ADDR, bit_v);
        @(posedge sys_clk_i);
        src <= bit_v[6:0];
        wr(ALARM_FLAGS_ADDR, bit_v);
        rd(ALARM_FLAGS_ADDR, bit_v);
        @(posedge sys_clk_i);
        src <= '0;
        wr(ALARM_FLAGS_ADDR, bit_v);
        rd(ALARM_FLAGS_ADDR, 8'h00);
        chk_out(8'h00);
      end
    end
    // several flags together, cleared one at a time
    cfg();
    @(posedge sys_clk_i);
    src <= 7'h7f;
    @(posedge sys_clk_i);
    src <= '0;
    chk_out(8'h7f);
    for (int b = 0; b < 7; b++)
    begin
      wr(ALARM_FLAGS_ADDR, 8'h01 << b);
      chk_out(8'h7f & ~((8'h02 << b) - 8'h01));
    end
    // threshold flag set together with out-of-sync; both threshold sides
    for (int s = 0; s < 2; s++)
    begin
      wr(ALARM_FLAGS_ADDR, 8'h7f);
      thr_sel <= 1'(s);
      src <= 7'h41;
      @(posedge sys_clk_i);
      src <= '0;
      rd(ALARM_FLAGS_ADDR, 8'h41);
    end
    close_out();
  end

endmodule // tb

`default_nettype wire
